// *** rtl/flpr_ctl.sv ***
// Command interpreter for global lock, lock read, power-down and reset handling.
`timescale 1ns/1ps

module flpr_ctl
   import flpr_pkg::*;
#(
   parameter logic [`FLPR_REC_W-1:0] RDPD_CYC = `FLPR_REC_W'(`FLPR_RDPD_CYC),
   parameter logic [`FLPR_REC_W-1:0] RUDPD_CYC = `FLPR_REC_W'(`FLPR_RUDPD_CYC)
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   input wire logic hw_reset_n_pin,
   input wire logic hw_reset_enable,
   input wire logic jedec_reset,
   input wire logic power_down_select,
   input wire logic lock_scheme_select,
   input wire logic op_busy,
   output logic op_start,
   output flpr_op_cmd_t op_cmd,
   output logic op_halt,
   output logic dev_reset,
   output logic buf_lost,
   output logic light_power_down_state,
   output logic ultra_power_down_state,
   output logic recovering
);

   flpr_ctl_st_t st_q;
   flpr_ctl_st_t st_d;
   logic [7:0] rx_byte;
   logic rx_tgl;
   logic byte_ev;
   logic frame_end;
   logic hwr_fall;
   logic reset_ev;
   logic single;
   logic [6:0] lidx;
   flpr_op_class_t cls;

   flpr_link u_link (
      .sck(sck),
      .cs_n(cs_n),
      .resetn(resetn),
      .si(si),
      .lock_byte(st_q.lock_byte),
      .lock_tgl(st_q.lock_tgl),
      .rx_byte(rx_byte),
      .rx_tgl(rx_tgl),
      .so(so),
      .so_oe_n(so_oe_n)
   );

   // Maps a block number and sub-block number to its position in the lock field.
   function automatic logic [6:0] lock_index(input logic [5:0] blk, input logic [3:0] sub);
      logic [6:0] r;
      r = 7'h0;
      if (blk == 6'h0) begin
         r = {3'h0, sub};
      end else if (blk == `FLPR_LOCK_LAST_BLOCK) begin
         r = 7'(`FLPR_LOCK_TOP_BASE) + {3'h0, sub};
      end else begin
         r = 7'(`FLPR_LOCK_MID_OFFSET) + {1'b0, blk};
      end
      return r;
   endfunction : lock_index

   // Sorts an opcode into program, erase or neither.
   function automatic flpr_op_class_t classify(input logic [7:0] op);
      flpr_op_class_t c;
      c = OPC_NONE;
      case (op)
         `FLPR_OP_PROG_PAGE, `FLPR_OP_PROG_SEQ_A, `FLPR_OP_PROG_SEQ_B,
         `FLPR_OP_PROG_DUAL, `FLPR_OP_PROG_QUAD, `FLPR_OP_PROG_RMW,
         `FLPR_OP_PROG_NO_ERASE, `FLPR_OP_PROG_SECURITY: begin
            c = OPC_PROGRAM;
         end
         `FLPR_OP_ERASE_PAGE_A, `FLPR_OP_ERASE_PAGE_B, `FLPR_OP_ERASE_4K,
         `FLPR_OP_ERASE_32K, `FLPR_OP_ERASE_64K, `FLPR_OP_ERASE_CHIP_A,
         `FLPR_OP_ERASE_CHIP_B: begin
            c = OPC_ERASE;
         end
         default: begin
            c = OPC_NONE;
         end
      endcase
      return c;
   endfunction : classify

   always_comb begin
      st_d = st_q;
      st_d.op_start = 1'b0;
      st_d.op_halt = 1'b0;
      st_d.dev_reset = 1'b0;
      st_d.buf_lost = 1'b0;

      st_d.byte_sync = {st_q.byte_sync[1:0], rx_tgl};
      st_d.cs_sync = {st_q.cs_sync[1:0], cs_n};
      st_d.hwr_sync = {st_q.hwr_sync[0], hw_reset_n_pin};
      st_d.hwr_prev = st_q.hwr_sync[1];

      byte_ev = st_q.byte_sync[2] != st_q.byte_sync[1];
      frame_end = st_q.cs_sync[1] & ~st_q.cs_sync[2];
      hwr_fall = st_q.hwr_prev & ~st_q.hwr_sync[1];
      reset_ev = jedec_reset | (hw_reset_enable & hwr_fall);
      single = st_q.byte_idx == 3'h1;
      cls = classify(st_q.opcode);
      lidx = lock_index(st_q.addr[21:16], st_q.addr[15:12]);

      // Byte collection; the lock field is looked up as soon as the sub-block is known.
      if (byte_ev) begin
         if (st_q.byte_idx != 3'h7) begin
            st_d.byte_idx = 3'(st_q.byte_idx + 3'h1);
         end
         case (st_q.byte_idx)
            3'h0: begin
               st_d.opcode = rx_byte;
            end
            3'h1: begin
               st_d.addr[23:16] = rx_byte;
            end
            3'h2: begin
               st_d.addr[15:8] = rx_byte;
               if (st_q.pwr == PWR_ACTIVE && (st_q.opcode == `FLPR_OP_LOCK_READ_A ||
                   st_q.opcode == `FLPR_OP_LOCK_READ_B)) begin
                  st_d.lock_byte = 8'h00;
                  st_d.lock_byte[`FLPR_LOCK_FLAG_POS] =
                     st_q.lock_bits[lock_index(st_q.addr[21:16], rx_byte[7:4])];
                  st_d.lock_tgl = ~st_q.lock_tgl;
               end
            end
            3'h3: begin
               st_d.addr[7:0] = rx_byte;
            end
            default: begin
            end
         endcase
      end

      // Commands take effect when chip select rises; the rise by itself wakes nothing.
      if (frame_end && st_q.byte_idx != 3'h0) begin
         st_d.byte_idx = 3'h0;
         st_d.rst_armed = 1'b0;
         case (st_q.pwr)
            PWR_ACTIVE: begin
               if (single && st_q.opcode == `FLPR_OP_GLOBAL_LOCK) begin
                  st_d.lock_bits = `FLPR_LOCK_ALL;
               end else if (single && st_q.opcode == `FLPR_OP_GLOBAL_UNLOCK) begin
                  st_d.lock_bits = `FLPR_LOCK_RESET;
               end else if (single && st_q.opcode == `FLPR_OP_POWER_DOWN) begin
                  if (power_down_select) begin
                     st_d.pwr = PWR_LIGHT;
                  end else begin
                     st_d.pwr = PWR_ULTRA;
                     st_d.buf_lost = 1'b1;
                  end
               end else if (single && st_q.opcode == `FLPR_OP_ULTRA_DOWN) begin
                  st_d.pwr = PWR_ULTRA;
                  st_d.buf_lost = 1'b1;
               end else if (single && st_q.opcode == `FLPR_OP_RESET_ENABLE) begin
                  st_d.rst_armed = 1'b1;
               end else if (single && st_q.opcode == `FLPR_OP_RESET_DEVICE) begin
                  st_d.dev_reset = st_q.rst_armed;
               end else if (single && st_q.opcode == `FLPR_OP_TERMINATE) begin
                  st_d.op_halt = op_busy;
               end else if (cls != OPC_NONE && !op_busy) begin
                  st_d.op_start = 1'b1;
                  st_d.op_cmd.cls = cls;
                  st_d.op_cmd.opcode = st_q.opcode;
                  st_d.op_cmd.addr = st_q.addr;
                  if (st_q.opcode == `FLPR_OP_ERASE_CHIP_A ||
                      st_q.opcode == `FLPR_OP_ERASE_CHIP_B) begin
                     st_d.op_cmd.blocked = lock_scheme_select & (|st_q.lock_bits);
                  end else begin
                     st_d.op_cmd.blocked = lock_scheme_select & st_q.lock_bits[lidx];
                  end
               end
            end
            PWR_LIGHT: begin
               if (single && st_q.opcode == `FLPR_OP_RESUME) begin
                  st_d.pwr = PWR_RECOVER;
                  st_d.rec_cnt = RDPD_CYC;
               end else if (single && st_q.opcode == `FLPR_OP_RESET_ENABLE) begin
                  st_d.rst_armed = 1'b1;
               end else if (single && st_q.opcode == `FLPR_OP_RESET_DEVICE &&
                            st_q.rst_armed) begin
                  st_d.pwr = PWR_ACTIVE;
                  st_d.dev_reset = 1'b1;
               end
            end
            PWR_ULTRA: begin
               // Terminate and the software reset pair fall through untouched here.
               if (single && st_q.opcode == `FLPR_OP_RESUME) begin
                  st_d.pwr = PWR_INT_RESET;
                  st_d.rec_cnt = RUDPD_CYC;
                  st_d.buf_lost = 1'b1;
               end
            end
            PWR_RECOVER, PWR_INT_RESET: begin
            end
            default: begin
               st_d.pwr = PWR_ACTIVE;
            end
         endcase
      end else if (frame_end) begin
         st_d.byte_idx = 3'h0;
      end

      // Recovery counts run down to idle; the internal reset fires at its end.
      if (st_q.pwr == PWR_RECOVER || st_q.pwr == PWR_INT_RESET) begin
         if (st_q.rec_cnt <= `FLPR_REC_W'(1)) begin
            st_d.rec_cnt = '0;
            st_d.pwr = PWR_ACTIVE;
            st_d.dev_reset = st_q.pwr == PWR_INT_RESET;
         end else begin
            st_d.rec_cnt = `FLPR_REC_W'(st_q.rec_cnt - `FLPR_REC_W'(1));
         end
      end

      // External resets override the power state, recovery count, reset arming and pulses and leave any power-down state.
      if (reset_ev) begin
         st_d.pwr = PWR_ACTIVE;
         st_d.rec_cnt = '0;
         st_d.rst_armed = 1'b0;
         st_d.dev_reset = 1'b1;
         st_d.buf_lost = 1'b1;
         st_d.op_start = 1'b0;
         st_d.op_halt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
         st_q.byte_sync <= 3'h0;
         st_q.cs_sync <= 3'h7;
         st_q.hwr_sync <= 2'h3;
         st_q.hwr_prev <= 1'b1;
         st_q.pwr <= PWR_ACTIVE;
         st_q.lock_bits <= `FLPR_LOCK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign op_start = st_q.op_start;
   assign op_cmd = st_q.op_cmd;
   assign op_halt = st_q.op_halt;
   assign dev_reset = st_q.dev_reset;
   assign buf_lost = st_q.buf_lost;
   assign light_power_down_state = st_q.pwr == PWR_LIGHT;
   assign ultra_power_down_state = st_q.pwr == PWR_ULTRA;
   assign recovering = st_q.pwr == PWR_RECOVER || st_q.pwr == PWR_INT_RESET;

endmodule : flpr_ctl

// *** rtl/flpr_link.sv ***
// Serial-clock side of the interpreter: byte capture and lock-field shift-out.
`timescale 1ns/1ps

module flpr_link
   import flpr_pkg::*;
(
   input wire logic sck,
   input wire logic cs_n,
   input wire logic resetn,
   input wire logic si,
   input wire logic [7:0] lock_byte,
   input wire logic lock_tgl,
   output logic [7:0] rx_byte,
   output logic rx_tgl,
   output logic so,
   output logic so_oe_n
);

   flpr_link_st_t st_q;
   flpr_link_st_t st_d;
   logic fresh_q;
   logic [2:0] cnt;
   logic [2:0] idx;
   logic [7:0] full;

   // Marks the first serial edge of a frame; the serial clock stands still between frames.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   always_comb begin
      st_d = st_q;
      cnt = fresh_q ? 3'h0 : st_q.bit_cnt;
      idx = fresh_q ? 3'h0 : st_q.byte_idx;
      full = {st_q.shift, si};
      if (fresh_q) begin
         st_d.loaded = 1'b0;
         st_d.drive = 1'b0;
      end
      st_d.ld_sync = {st_q.ld_sync[0], lock_tgl};
      st_d.shift = full[6:0];
      st_d.bit_cnt = 3'(cnt + 3'h1);
      if (st_d.drive) begin
         st_d.out_sr = {st_q.out_sr[6:0], 1'b0};
      end else if (st_q.ld_sync[1] != st_q.ld_seen) begin
         st_d.out_sr = lock_byte;
         st_d.loaded = 1'b1;
      end
      st_d.ld_seen = st_q.ld_sync[1];
      if (cnt == 3'h7) begin
         st_d.rx_byte = full;
         st_d.rx_tgl = ~st_q.rx_tgl;
         if (idx != 3'h7) begin
            st_d.byte_idx = 3'(idx + 3'h1);
         end
         if (idx == 3'h0) begin
            st_d.is_lockrd = (full == `FLPR_OP_LOCK_READ_A) ||
                             (full == `FLPR_OP_LOCK_READ_B);
         end
         // The most significant bit is presented before the first output edge.
         if (idx == 3'h3 && st_q.is_lockrd && st_d.loaded) begin
            st_d.drive = 1'b1;
         end
      end else begin
         st_d.byte_idx = idx;
      end
   end

   always_ff @(posedge sck or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rx_byte = st_q.rx_byte;
   assign rx_tgl = st_q.rx_tgl;
   assign so = st_q.out_sr[7];
   assign so_oe_n = ~st_q.drive | cs_n;

endmodule : flpr_link

// *** shared/flpr_map.svh ***
// Opcodes, lock-bit layout, reset values and recovery timing of the flash command interpreter.
`ifndef FLPR_MAP_SVH
`define FLPR_MAP_SVH

`define FLPR_OP_GLOBAL_LOCK 8'h7E
`define FLPR_OP_GLOBAL_UNLOCK 8'h98
`define FLPR_OP_LOCK_READ_A 8'h3C
`define FLPR_OP_LOCK_READ_B 8'h3D
`define FLPR_OP_POWER_DOWN 8'hB9
`define FLPR_OP_ULTRA_DOWN 8'h79
`define FLPR_OP_RESUME 8'hAB
`define FLPR_OP_RESET_ENABLE 8'h66
`define FLPR_OP_RESET_DEVICE 8'h99
`define FLPR_OP_TERMINATE 8'hF0

`define FLPR_OP_PROG_PAGE 8'h02
`define FLPR_OP_PROG_SEQ_A 8'hAF
`define FLPR_OP_PROG_SEQ_B 8'hAD
`define FLPR_OP_PROG_DUAL 8'hA2
`define FLPR_OP_PROG_QUAD 8'h32
`define FLPR_OP_PROG_RMW 8'h0A
`define FLPR_OP_PROG_NO_ERASE 8'h88
`define FLPR_OP_PROG_SECURITY 8'h9B
`define FLPR_OP_ERASE_PAGE_A 8'h81
`define FLPR_OP_ERASE_PAGE_B 8'hDB
`define FLPR_OP_ERASE_4K 8'h20
`define FLPR_OP_ERASE_32K 8'h52
`define FLPR_OP_ERASE_64K 8'hD8
`define FLPR_OP_ERASE_CHIP_A 8'h60
`define FLPR_OP_ERASE_CHIP_B 8'hC7

// Lock field layout: 16 sub-blocks of block 0, blocks 1..62, 16 sub-blocks of block 63.
`define FLPR_LOCK_BITS 94
`define FLPR_LOCK_TOP_BASE 78
`define FLPR_LOCK_MID_OFFSET 15
`define FLPR_LOCK_LAST_BLOCK 6'h3F
`define FLPR_LOCK_RESET 94'h0
`define FLPR_LOCK_ALL 94'h3FFF_FFFF_FFFF_FFFF_FFFF_FFFF

// Bit position of the lock flag inside the returned 8-bit lock field.
`define FLPR_LOCK_FLAG_POS 0

// Recovery timing.
`define FLPR_CLK_MHZ 200
`define FLPR_T_RDPD_NS 3000
`define FLPR_T_RUDPD_NS 10000
`define FLPR_RDPD_CYC ((`FLPR_T_RDPD_NS * `FLPR_CLK_MHZ + 999) / 1000)
`define FLPR_RUDPD_CYC ((`FLPR_T_RUDPD_NS * `FLPR_CLK_MHZ + 999) / 1000)
`define FLPR_REC_W 12

`endif

// *** shared/flpr_pkg.sv ***
// Types shared by the flash lock, power-down and reset command interpreter.
`include "flpr_map.svh"

package flpr_pkg;

   typedef enum logic [2:0] {
      PWR_ACTIVE,
      PWR_LIGHT,
      PWR_ULTRA,
      PWR_RECOVER,
      PWR_INT_RESET
   } flpr_pwr_t;

   typedef enum logic [1:0] {
      OPC_NONE,
      OPC_PROGRAM,
      OPC_ERASE
   } flpr_op_class_t;

   typedef struct packed {
      flpr_op_class_t cls;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic blocked;
   } flpr_op_cmd_t;

   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [2:0] byte_idx;
      logic [6:0] shift;
      logic [7:0] rx_byte;
      logic rx_tgl;
      logic is_lockrd;
      logic [1:0] ld_sync;
      logic ld_seen;
      logic loaded;
      logic [7:0] out_sr;
      logic drive;
   } flpr_link_st_t;

   typedef struct packed {
      logic [2:0] byte_sync;
      logic [2:0] cs_sync;
      logic [1:0] hwr_sync;
      logic hwr_prev;
      logic [2:0] byte_idx;
      logic [7:0] opcode;
      logic [23:0] addr;
      flpr_pwr_t pwr;
      logic rst_armed;
      logic [`FLPR_REC_W-1:0] rec_cnt;
      logic [`FLPR_LOCK_BITS-1:0] lock_bits;
      logic [7:0] lock_byte;
      logic lock_tgl;
      flpr_op_cmd_t op_cmd;
      logic op_start;
      logic op_halt;
      logic dev_reset;
      logic buf_lost;
   } flpr_ctl_st_t;

endpackage : flpr_pkg

// *** verification/flpr_ctl_chk.sv ***
// Port-level checks on the flash lock, power-down and reset command interpreter.
`timescale 1ns/1ps
module flpr_ctl_chk
   import flpr_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic so_oe_n,
   input wire logic hw_reset_n_pin,
   input wire logic hw_reset_enable,
   input wire logic jedec_reset,
   input wire logic lock_scheme_select,
   input wire logic op_busy,
   input wire logic op_start,
   input wire flpr_op_cmd_t op_cmd,
   input wire logic op_halt,
   input wire logic dev_reset,
   input wire logic buf_lost,
   input wire logic light_power_down_state,
   input wire logic ultra_power_down_state,
   input wire logic recovering
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   a_pd_exclusive: assert property (!(light_power_down_state && ultra_power_down_state))
      else $error("both power-down states set");
   a_ultra_loses: assert property ($rose(ultra_power_down_state) |-> buf_lost)
      else $error("ultra entry without buffer loss");
   a_light_keeps: assert property ($rose(light_power_down_state) |-> !buf_lost)
      else $error("light entry lost the buffer");
   a_pd_quiet: assert property ((light_power_down_state || ultra_power_down_state)
      |-> !op_start && !op_halt) else $error("operation issued in power-down");
   a_halt_soft: assert property (op_halt |-> $past(op_busy) && !dev_reset)
      else $error("halt without busy op or with reset");
   a_pin_wakes: assert property (hw_reset_enable && $fell(hw_reset_n_pin)
      |-> ##[1:4] (dev_reset && buf_lost)) else $error("reset pin not acted on");
   a_jedec_wakes: assert property (jedec_reset |-> ##[1:2] (dev_reset && buf_lost))
      else $error("pin-sequence reset not acted on");
   a_scheme_off: assert property (op_start && !lock_scheme_select |-> !op_cmd.blocked)
      else $error("blocked with lock scheme off");
   a_start_class: assert property (op_start |-> op_cmd.cls != OPC_NONE)
      else $error("operation started without class");
   a_so_release: assert property (cs_n |-> so_oe_n)
      else $error("serial output driven while deselected");
   a_rec_quiet: assert property (recovering |-> !op_start && !op_halt)
      else $error("operation issued during recovery");
endmodule : flpr_ctl_chk

bind flpr_ctl flpr_ctl_chk u_chk (
   .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .so_oe_n(so_oe_n),
   .hw_reset_n_pin(hw_reset_n_pin), .hw_reset_enable(hw_reset_enable),
   .jedec_reset(jedec_reset), .lock_scheme_select(lock_scheme_select), .op_busy(op_busy),
   .op_start(op_start), .op_cmd(op_cmd), .op_halt(op_halt), .dev_reset(dev_reset),
   .buf_lost(buf_lost), .light_power_down_state(light_power_down_state),
   .ultra_power_down_state(ultra_power_down_state), .recovering(recovering)
);

// *** verification/flpr_host.sv ***
// Behavioural SPI host that issues command frames in mode 0 and reads the lock field.
`timescale 1ns/1ps
module flpr_host (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // Clock stands low outside frames; released data shows the inverse of its last bit.
   task automatic frame(input logic [31:0] data, input int nbytes, input int nread,
                        output logic [7:0] rd);
      rd = 8'h00;
      #1.3 cs_n = 1'b0;
      for (int i = 0; i < 8 * (nbytes + nread); i++) begin
         si = (i < 8 * nbytes) ? data[31-i] : 1'b0;
         if (i >= 8 * nbytes) rd = {rd[6:0], so_oe_n ? 1'bx : so};
         #40 sck = 1'b1;
         #40 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask : frame
endmodule : flpr_host

// *** verification/tb.sv ***
// Self-checking bench for the flash lock, power-down and reset interpreter.
`timescale 1ns/1ps
module tb;
   import flpr_pkg::*;
   localparam int REC_L = 4;
   localparam int REC_U = 8;
   localparam int LIMIT = 80000;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic hw_reset_n_pin = 1'b1;
   logic hw_reset_enable = 1'b0;
   logic jedec_reset = 1'b0;
   logic power_down_select = 1'b0;
   logic lock_scheme_select = 1'b0;
   logic op_busy = 1'b0;
   logic sck, cs_n, si, so, so_oe_n, op_start, op_halt, dev_reset, buf_lost, light, ultra, rec;
   flpr_op_cmd_t op_cmd, last_cmd;
   logic [7:0] rd;
   int miscompares = 0;
   int comparisons = 0;
   int n_start, n_halt, n_rst, n_lost, n_rec;
   int cyc = 0;
   always #2.5 mclk = ~mclk;
   flpr_ctl #(.RDPD_CYC(12'h004), .RUDPD_CYC(12'h008)) u_dut (
      .mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
      .so_oe_n(so_oe_n), .hw_reset_n_pin(hw_reset_n_pin), .hw_reset_enable(hw_reset_enable),
      .jedec_reset(jedec_reset), .power_down_select(power_down_select),
      .lock_scheme_select(lock_scheme_select), .op_busy(op_busy), .op_start(op_start),
      .op_cmd(op_cmd), .op_halt(op_halt), .dev_reset(dev_reset), .buf_lost(buf_lost),
      .light_power_down_state(light), .ultra_power_down_state(ultra), .recovering(rec));
   flpr_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
   always @(posedge mclk) begin
      cyc++;
      if (op_start === 1'b1) begin
         n_start++;
         last_cmd = op_cmd;
      end
      if (op_halt === 1'b1) n_halt++;
      if (dev_reset === 1'b1) n_rst++;
      if (buf_lost === 1'b1) n_lost++;
      if (rec === 1'b1) n_rec++;
      if (cyc == LIMIT) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic clr();
      n_start = 0;
      n_halt = 0;
      n_rst = 0;
      n_lost = 0;
      n_rec = 0;
   endtask : clr
   task automatic cmd(input logic [7:0] op);
      @(posedge mclk);
      u_host.frame({op, 24'h00_0000}, 1, 0, rd);
   endtask : cmd
   task automatic rdlock(input logic [7:0] op, input logic [23:0] a);
      @(posedge mclk);
      u_host.frame({op, a}, 4, 1, rd);
   endtask : rdlock
   task automatic rst_ev(input logic pin);
      @(posedge mclk);
      if (pin) hw_reset_n_pin <= 1'b0;
      else jedec_reset <= 1'b1;
      @(posedge mclk) jedec_reset <= 1'b0;
      repeat (8) @(posedge mclk);
      hw_reset_n_pin <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask : rst_ev
   task automatic t_lock();
      rdlock(8'h3C, 24'h12_3400);
      chk("lock field at reset", 8'h00, rd);
      cmd(8'h7E);
      rdlock(8'h3C, 24'h3F_F000);
      chk("lock field after lock", 8'h01, rd);
      rdlock(8'h3D, 24'h00_1000);
      chk("lock field second opcode", 8'h01, rd);
      cmd(8'h98);
      rdlock(8'h3D, 24'h20_0000);
      chk("lock field after unlock", 8'h00, rd);
   endtask : t_lock
   task automatic t_class();
      logic [7:0] ops [15] = '{8'h02, 8'hAF, 8'hAD, 8'hA2, 8'h32, 8'h0A, 8'h88, 8'h9B,
                               8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
      cmd(8'h7E);
      @(posedge mclk) lock_scheme_select <= 1'b1;
      foreach (ops[i]) begin
         n_start = 0;
         @(posedge mclk);
         u_host.frame({ops[i], 24'h01_0000}, 4, 0, rd);
         chk("start count", 1, n_start);
         chk("op class", (i < 8) ? OPC_PROGRAM : OPC_ERASE, last_cmd.cls);
         chk("op code", ops[i], last_cmd.opcode);
         chk("op addr", 24'h01_0000, last_cmd.addr);
         chk("op blocked", 1'b1, last_cmd.blocked);
      end
      @(posedge mclk) lock_scheme_select <= 1'b0;
      u_host.frame({8'h02, 24'h01_0000}, 4, 0, rd);
      chk("op blocked, scheme off", 1'b0, last_cmd.blocked);
      cmd(8'h98);
      n_start = 0;
      @(posedge mclk) lock_scheme_select <= 1'b1;
      u_host.frame({8'h20, 24'h01_0000}, 4, 0, rd);
      chk("start count unlocked", 1, n_start);
      chk("op blocked, unlocked", 1'b0, last_cmd.blocked);
      @(posedge mclk) lock_scheme_select <= 1'b0;
   endtask : t_class
   task automatic t_light();
      @(posedge mclk) power_down_select <= 1'b1;
      clr();
      cmd(8'hB9);
      chk("light state", 1'b1, light);
      cmd(8'hF0);
      cmd(8'h7E);
      rst_ev(1'b1);
      chk("light held", 1'b1, light);
      chk("pin while disabled", 0, n_rst);
      cmd(8'hAB);
      chk("light after resume", 1'b0, light);
      chk("light recovery", REC_L, n_rec);
      chk("resume side effects", 0, n_rst + n_lost);
      rdlock(8'h3C, 24'h00_0000);
      chk("lock field untouched", 8'h00, rd);
      cmd(8'hB9);
      cmd(8'h66);
      cmd(8'h99);
      chk("light after reset pair", 1'b0, light);
      chk("buffer loss", 0, n_lost);
   endtask : t_light
   task automatic t_ultra();
      @(posedge mclk) power_down_select <= 1'b0;
      hw_reset_enable <= 1'b1;
      clr();
      cmd(8'hB9);
      chk("ultra state", 1'b1, ultra);
      chk("ultra loss", 1, n_lost);
      cmd(8'h66);
      cmd(8'h99);
      cmd(8'hF0);
      chk("ultra held", 1'b1, ultra);
      cmd(8'hAB);
      chk("ultra after resume", 1'b0, ultra);
      chk("ultra recovery", REC_U, n_rec);
      chk("internal reset", 1, n_rst);
      @(posedge mclk) power_down_select <= 1'b1;
      cmd(8'h79);
      chk("legacy ultra", 1'b1, ultra);
      clr();
      rst_ev(1'b1);
      chk("pin exit", 5'h01, {ultra, n_rst[3:0]});
      cmd(8'h79);
      rst_ev(1'b0);
      chk("sequence exit", 5'h02, {ultra, n_rst[3:0]});
   endtask : t_ultra
   task automatic t_busy();
      @(posedge mclk) op_busy <= 1'b1;
      clr();
      cmd(8'hF0);
      chk("halt count", 1, n_halt);
      chk("halt resets", 0, n_rst);
      cmd(8'h66);
      cmd(8'h99);
      chk("pair reset", 1, n_rst);
      rst_ev(1'b1);
      rst_ev(1'b0);
      chk("reset in op", 3, n_rst);
      op_busy <= 1'b0;
      cmd(8'h7E);
      cmd(8'hB9);
      @(posedge mclk) resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("power-on exit", 1'b0, light);
      rdlock(8'h3C, 24'h00_0000);
      chk("lock field after power-on", 8'h00, rd);
   endtask : t_busy
   task automatic give_verdict();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clr();
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      t_lock();
      t_class();
      t_light();
      t_ultra();
      t_busy();
      give_verdict();
   end
endmodule : tb
